// [quad_dac_serial_control.sv]
// Purpose: Register control of a quad 8-bit DAC behind a serial link
// Assumes: ref_clk 40 MHz; pins asynchronous to it
// Notes: Commands execute one cycle after chip select rise is seen
`timescale 1ns/1ps
module quad_dac_serial_control
(
   input wire logic ref_clk,
   input wire logic rst_n,
   input wire logic sclk,
   input wire logic cs_n,
   input wire logic din,
   input wire logic load_strobe_n,
   input wire logic clear_n,
   output logic dout,
   output logic [7:0] dac_a,
   output logic [7:0] dac_b,
   output logic [7:0] dac_c,
   output logic [7:0] dac_d,
   output logic mode_rising
);

   serial_if sif ();

   logic [7:0] input_ff [4];
   logic [7:0] dac_ff [4];
   logic mode_ff;
   logic [2:0] ld_ff;
   logic [2:0] clr_ff;
   logic load_w;
   logic clear_w;
   logic [1:0] addr_w;
   logic [1:0] cmd_w;
   logic [7:0] data_w;
   logic exec_w;

   // ------------------------------------------------------------
   // Serial front end
   // ------------------------------------------------------------
   serial_shifter u_shift
   (
      .ref_clk(ref_clk),
      .rst_n(rst_n),
      .clear_n(clear_n),
      .sclk(sclk),
      .cs_n(cs_n),
      .din(din),
      .mode_rising(mode_ff),
      .dout(dout),
      .sif(sif)
   );

   // Control pin synchronisers
   always_ff @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         ld_ff <= 3'h7;
         clr_ff <= 3'h7;
      end
      else
      begin
         ld_ff <= {ld_ff[1:0], load_strobe_n};
         clr_ff <= {clr_ff[1:0], clear_n};
      end
   end

   // Levels valid once stages two and three agree
   assign load_w = ~ld_ff[1] & ~ld_ff[2];
   assign clear_w = ~clr_ff[1] & ~clr_ff[2];

   // Word fields
   assign addr_w = sif.word[dac_ctrl_pkg::ADDR_HI_POS:
                            dac_ctrl_pkg::ADDR_LO_POS];
   assign cmd_w = sif.word[dac_ctrl_pkg::CMD_HI_POS:
                           dac_ctrl_pkg::CMD_LO_POS];
   assign data_w = sif.word[dac_ctrl_pkg::DATA_MSB_POS:0];
   assign exec_w = sif.frame_end;

   // ------------------------------------------------------------
   // Registers
   // ------------------------------------------------------------
   // Command execution, clear overrides, strobe copies continuously
   always_ff @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         for (int i = 0; i < dac_ctrl_pkg::CHANNELS; i++)
         begin
            input_ff[i] <= dac_ctrl_pkg::CODE_RESET;
            dac_ff[i] <= dac_ctrl_pkg::CODE_RESET;
         end
         mode_ff <= dac_ctrl_pkg::MODE_RISING;
      end
      else if (clear_w)
      begin
         for (int i = 0; i < dac_ctrl_pkg::CHANNELS; i++)
         begin
            input_ff[i] <= dac_ctrl_pkg::CODE_RESET;
            dac_ff[i] <= dac_ctrl_pkg::CODE_RESET;
         end
      end
      else
      begin
         if (load_w)
            for (int i = 0; i < dac_ctrl_pkg::CHANNELS; i++)
               dac_ff[i] <= input_ff[i];
         if (exec_w)
         begin
            unique case (cmd_w)
               dac_ctrl_pkg::CMD_LOAD_INPUT:
                  input_ff[addr_w] <= data_w;
               dac_ctrl_pkg::CMD_LOAD_BOTH:
               begin
                  input_ff[addr_w] <= data_w;
                  dac_ff[addr_w] <= data_w;
               end
               dac_ctrl_pkg::CMD_ALL_OR_NOP:
                  if (!addr_w[0])
                     for (int i = 0; i < dac_ctrl_pkg::CHANNELS; i++)
                        dac_ff[i] <= data_w;
               dac_ctrl_pkg::CMD_UPDATE:
               begin
                  for (int i = 0; i < dac_ctrl_pkg::CHANNELS; i++)
                     dac_ff[i] <= input_ff[i];
                  if (addr_w[1])
                     mode_ff <= addr_w[0];
               end
            endcase
         end
      end
   end

   assign dac_a = dac_ff[0];
   assign dac_b = dac_ff[1];
   assign dac_c = dac_ff[2];
   assign dac_d = dac_ff[3];
   assign mode_rising = mode_ff;

   // ------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------
   property p_clear;
      @(posedge ref_clk) disable iff (!rst_n)
      clear_w |=> (dac_ff[0] == 8'h00 && input_ff[3] == 8'h00);
   endproperty
   a_clear: assert property (p_clear) else $error("clear failed");

   property p_strobe;
      @(posedge ref_clk) disable iff (!rst_n)
      (load_w && !clear_w && !exec_w) |=> (dac_ff[1] == $past(input_ff[1]));
   endproperty
   a_strobe: assert property (p_strobe) else $error("strobe copy");

   property p_load_input;
      @(posedge ref_clk) disable iff (!rst_n)
      (exec_w && !clear_w && cmd_w == 2'h1 && addr_w == 2'h2)
      |=> input_ff[2] == $past(data_w);
   endproperty
   a_load_input: assert property (p_load_input) else $error("load");

   property p_load_both;
      @(posedge ref_clk) disable iff (!rst_n)
      (exec_w && !clear_w && cmd_w == 2'h3 && addr_w == 2'h0)
      |=> dac_ff[0] == $past(data_w);
   endproperty
   a_load_both: assert property (p_load_both) else $error("both");

   property p_mode;
      @(posedge ref_clk) disable iff (!rst_n)
      (exec_w && !clear_w && cmd_w == 2'h2 && addr_w == 2'h2)
      |=> !mode_ff;
   endproperty
   a_mode: assert property (p_mode) else $error("mode set");

   property p_all;
      @(posedge ref_clk) disable iff (!rst_n)
      (exec_w && !clear_w && cmd_w == 2'h0 && !addr_w[0])
      |=> dac_ff[3] == $past(data_w);
   endproperty
   a_all: assert property (p_all) else $error("load all");

   property p_exec_only_on_cs;
      @(posedge ref_clk) disable iff (!rst_n)
      (!exec_w && !load_w && !clear_w) |=> $stable(dac_ff[2]);
   endproperty
   a_exec_only_on_cs: assert property (p_exec_only_on_cs)
      else $error("dac moved");

   property p_dout_hold;
      @(posedge ref_clk) disable iff (!rst_n)
      (cs_n && $past(cs_n) && $past(cs_n, 2) && $past(cs_n, 3))
      |=> $stable(dout);
   endproperty
   a_dout_hold: assert property (p_dout_hold) else $error("dout");

   property p_update;
      @(posedge ref_clk) disable iff (!rst_n)
      (exec_w && !clear_w && cmd_w == 2'h2)
      |=> dac_ff[2] == $past(input_ff[2]);
   endproperty
   a_update: assert property (p_update) else $error("update");

   property p_nop;
      @(posedge ref_clk) disable iff (!rst_n)
      (exec_w && !clear_w && !load_w && cmd_w == 2'h0 && addr_w[0])
      |=> $stable(dac_ff[1]);
   endproperty
   a_nop: assert property (p_nop) else $error("nop moved dac");

   property p_mode_rise;
      @(posedge ref_clk) disable iff (!rst_n)
      (exec_w && !clear_w && cmd_w == 2'h2 && addr_w == 2'h3)
      |=> mode_ff;
   endproperty
   a_mode_rise: assert property (p_mode_rise) else $error("mode");

   property p_input_only;
      @(posedge ref_clk) disable iff (!rst_n)
      (exec_w && !clear_w && !load_w && cmd_w == 2'h1 && addr_w == 2'h1)
      |=> ($stable(dac_ff[1]) && input_ff[1] == $past(data_w));
   endproperty
   a_input_only: assert property (p_input_only) else $error("input");

endmodule : quad_dac_serial_control

// [dac_ctrl_pkg.sv]
// Purpose: Shared constants for the quad DAC serial control block
// Assumes: ref_clk at 40 MHz samples every input pin of the serial link
// Notes: Word layout, command codes and timing counts live here
package dac_ctrl_pkg;

   // ------------------------------------------------------------
   // Word layout
   // ------------------------------------------------------------
   localparam int WORD_BITS = 12;
   localparam int DATA_BITS = 8;
   localparam int CHANNELS = 4;
   localparam int ADDR_HI_POS = 11;
   localparam int ADDR_LO_POS = 10;
   localparam int CMD_HI_POS = 9;
   localparam int CMD_LO_POS = 8;
   localparam int DATA_MSB_POS = 7;

   // ------------------------------------------------------------
   // Command codes and reset values
   // ------------------------------------------------------------
   localparam logic [1:0] CMD_ALL_OR_NOP = 2'h0;
   localparam logic [1:0] CMD_LOAD_INPUT = 2'h1;
   localparam logic [1:0] CMD_UPDATE = 2'h2;
   localparam logic [1:0] CMD_LOAD_BOTH = 2'h3;
   localparam logic [7:0] CODE_RESET = 8'h00;
   localparam logic MODE_RISING = 1'b1;

   // ------------------------------------------------------------
   // Timing
   // ------------------------------------------------------------
   localparam int CLK_PERIOD_NS = 25;
   localparam int STROBE_MIN_NS = 40;
   localparam int STROBE_MIN_CYC =
      (STROBE_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

endpackage : dac_ctrl_pkg

// [serial_if.sv]
// Purpose: Carries the synchronised serial events to the control core
// Assumes: All signals on ref_clk
// Notes: Shifter drives, control core consumes
`timescale 1ns/1ps
interface serial_if;
   logic [11:0] word;
   logic frame_end;
   modport shifter (output word, output frame_end);
   modport core (input word, input frame_end);
endinterface : serial_if

// [serial_shifter.sv]
// Purpose: Samples the serial pins and shifts 12-bit words
// Assumes: Pins are asynchronous to ref_clk
// Notes: Three-stage synchronisers, edges seen when stages 2 and 3 differ
`timescale 1ns/1ps
module serial_shifter
(
   input wire logic ref_clk,
   input wire logic rst_n,
   input wire logic clear_n,
   input wire logic sclk,
   input wire logic cs_n,
   input wire logic din,
   input wire logic mode_rising,
   output logic dout,
   serial_if.shifter sif
);

   logic [2:0] sclk_ff;
   logic [2:0] cs_ff;
   logic [2:0] din_ff;
   logic [11:0] shift_ff;
   logic dout_ff;
   logic frame_ff;
   logic rise_w;
   logic fall_w;
   logic cs_rise_w;
   logic active_w;

   // ------------------------------------------------------------
   // Synchronisers
   // ------------------------------------------------------------
   // Power-on reset restarts the interface; clear only hits the registers
   always_ff @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         sclk_ff <= 3'h0;
         cs_ff <= 3'h7;
         din_ff <= 3'h0;
      end
      else
      begin
         sclk_ff <= {sclk_ff[1:0], sclk};
         cs_ff <= {cs_ff[1:0], cs_n};
         din_ff <= {din_ff[1:0], din};
      end
   end

   // Edge decode from stages two and three only
   assign rise_w = sclk_ff[1] & ~sclk_ff[2];
   assign fall_w = ~sclk_ff[1] & sclk_ff[2];
   assign active_w = ~cs_ff[1] & ~cs_ff[2];
   assign cs_rise_w = cs_ff[1] & ~cs_ff[2];

   // ------------------------------------------------------------
   // Shift register and serial output
   // ------------------------------------------------------------
   // Shift in on rising edges, output on the chosen edge
   always_ff @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         shift_ff <= 12'h000;
         dout_ff <= 1'b0;
         frame_ff <= 1'b0;
      end
      else
      begin
         if (active_w && rise_w)
            shift_ff <= {shift_ff[10:0], din_ff[2]};
         if (active_w && (mode_rising ? rise_w : fall_w))
            dout_ff <= shift_ff[11];
         frame_ff <= cs_rise_w;
      end
   end

   assign dout = dout_ff;
   assign sif.word = shift_ff;
   assign sif.frame_end = frame_ff;

   // ------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------
   property p_out_not_on_rise;
      @(posedge ref_clk) disable iff (!rst_n)
      (!mode_rising && rise_w) |=> $stable(dout_ff);
   endproperty
   a_out_not_on_rise: assert property (p_out_not_on_rise)
      else $error("dout moved on rise in falling mode");

   property p_out_not_on_fall;
      @(posedge ref_clk) disable iff (!rst_n)
      (mode_rising && fall_w) |=> $stable(dout_ff);
   endproperty
   a_out_not_on_fall: assert property (p_out_not_on_fall)
      else $error("dout moved on fall in rising mode");

   property p_out_bit;
      @(posedge ref_clk) disable iff (!rst_n)
      (active_w && mode_rising && rise_w)
      |=> dout_ff == $past(shift_ff[11]);
   endproperty
   a_out_bit: assert property (p_out_bit)
      else $error("dout is not the leaving bit");

   property p_no_shift_idle;
      @(posedge ref_clk) disable iff (!rst_n)
      !active_w |=> $stable(shift_ff);
   endproperty
   a_no_shift_idle: assert property (p_no_shift_idle)
      else $error("shift while deselected");

endmodule : serial_shifter

// [host_model.sv]
// Purpose: Host end of the serial link, sends words and reads dout back
// Assumes: Link clock of 200 ns, four ref_clk in each half period
// Notes: dout is sampled eight cycles after the edge that moves it
`timescale 1ns/1ps
module host_model
(
   input wire logic ref_clk,
   input wire logic dout,
   output logic sclk,
   output logic cs_n,
   output logic din
);
   // Link idles with the clock low and select high
   initial
   begin
      sclk = 1'b0;
      cs_n = 1'b1;
      din = 1'b0;
   end

   // ----------------------------------------------------
   // Link tasks
   // ----------------------------------------------------
   // Half a link period, pins change just after a clock edge
   task half;
      repeat (4) @(posedge ref_clk);
      #1;
   endtask : half

   // Clocks one word out MSB first and leaves select low
   task frame(input logic [11:0] w, input logic rise,
              output logic [11:0] rd);
      int i;
      cs_n = 1'b0;
      for (i = 11; i >= 0; i--)
      begin
         din = w[i];
         half();
         if (rise && i < 11) rd[i + 1] = dout;
         sclk = 1'b1;
         half();
         if (!rise) rd[i] = dout;
         sclk = 1'b0;
      end
      half();
      if (rise) rd[0] = dout;
      din = ~w[0];
   endtask : frame

   // Raises select so the word is carried out
   task deselect;
      cs_n = 1'b1;
   endtask : deselect

   // Clock pulses with select high, data toggling
   task idle(input int n);
      repeat (n)
      begin
         din = ~din;
         half();
         sclk = 1'b1;
         half();
         sclk = 1'b0;
      end
   endtask : idle

endmodule : host_model

// [tb_top.sv]
// Purpose: Self-checking bench for the quad DAC serial control block
// Assumes: ref_clk 40 MHz, commands take effect within 8 cycles
// Notes: A small model of the registers gives the expected DAC codes and mode
`timescale 1ns/1ps
module tb_top;
   logic ref_clk, rst_n, load_strobe_n, clear_n;
   logic sclk, cs_n, din, dout, mode_rising;
   logic [7:0] dac_a, dac_b, dac_c, dac_d;
   logic [7:0] inp_e [4];
   logic [7:0] dac_e [4];
   logic mode_e, prev_mode, rb_ok;
   logic [11:0] prev_w, rd;
   int bad_count, n_compared, k, j;
   localparam logic [191:0] WORDS = {12'h111, 12'h522, 12'h933,
      12'hd44, 12'h200, 12'h75a, 12'h0c3, 12'h4ee, 12'h8a5, 12'hc77,
      12'h1bd, 12'ha00, 12'h3e1, 12'hb96, 12'hf28, 12'he00};

   // ----------------------------------------------------
   // Clock and instances
   // ----------------------------------------------------
   initial ref_clk = 1'b0;
   always #12.5 ref_clk = ~ref_clk;

   quad_dac_serial_control quad_dac_serial_control_i (.ref_clk(ref_clk),
      .rst_n(rst_n), .sclk(sclk), .cs_n(cs_n), .din(din),
      .load_strobe_n(load_strobe_n), .clear_n(clear_n), .dout(dout),
      .dac_a(dac_a), .dac_b(dac_b), .dac_c(dac_c), .dac_d(dac_d),
      .mode_rising(mode_rising));
   host_model host_model_i (.ref_clk(ref_clk), .dout(dout), .sclk(sclk),
      .cs_n(cs_n), .din(din));

   // ----------------------------------------------------
   // Tasks
   // ----------------------------------------------------
   task cyc(input int n);
      repeat (n) @(posedge ref_clk);
      #1;
   endtask : cyc

   task chk(input string what, input logic [11:0] exp,
            input logic [11:0] got);
      n_compared++;
      if (got !== exp)
      begin
         bad_count++;
         $display("MISMATCH %s expected %h seen %h", what, exp, got);
      end
   endtask : chk

   // Compares all DAC codes and the output edge mode
   task chk_all;
      chk("dac_a", {4'h0, dac_e[0]}, {4'h0, dac_a});
      chk("dac_b", {4'h0, dac_e[1]}, {4'h0, dac_b});
      chk("dac_c", {4'h0, dac_e[2]}, {4'h0, dac_c});
      chk("dac_d", {4'h0, dac_e[3]}, {4'h0, dac_d});
      chk("mode", {11'h000, mode_e}, {11'h000, mode_rising});
   endtask : chk_all

   // Expected effect of one command word
   task model(input logic [11:0] w);
      if (w[8]) inp_e[w[11:10]] = w[7:0];
      if (w[9:8] == 2'h3) dac_e[w[11:10]] = w[7:0];
      for (k = 0; k < 4; k++)
      begin
         if (w[9:8] == 2'h0 && !w[10]) dac_e[k] = w[7:0];
         if (w[9:8] == 2'h2) dac_e[k] = inp_e[k];
      end
      if (w[9:8] == 2'h2 && w[11]) mode_e = w[10];
   endtask : model

   // One word: readback, no effect before select rises, then effect
   task send(input logic [11:0] w);
      host_model_i.frame(w, mode_e, rd);
      if (rb_ok && prev_mode === mode_e) chk("readback", prev_w, rd);
      prev_w = w;
      prev_mode = mode_e;
      rb_ok = 1'b1;
      chk_all();
      host_model_i.deselect();
      cyc(8);
      model(w);
      chk_all();
   endtask : send

   task strobe;
      load_strobe_n = 1'b0;
      cyc(dac_ctrl_pkg::STROBE_MIN_CYC + 2);
      load_strobe_n = 1'b1;
      cyc(4);
      for (k = 0; k < 4; k++) dac_e[k] = inp_e[k];
   endtask : strobe

   task test_done;
      $display("compared %0d mismatches %0d", n_compared, bad_count);
      if (bad_count == 0 && n_compared > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask : test_done

   // ----------------------------------------------------
   // Sequence
   // ----------------------------------------------------
   initial
   begin
      rst_n = 1'b0;
      load_strobe_n = 1'b1;
      clear_n = 1'b1;
      mode_e = 1'b1;
      prev_mode = 1'b1;
      rb_ok = 1'b1;
      prev_w = 12'h000;
      for (k = 0; k < 4; k++) inp_e[k] = 8'h00;
      for (k = 0; k < 4; k++) dac_e[k] = 8'h00;
      cyc(20);
      rst_n = 1'b1;
      cyc(6);
      chk_all();
      for (j = 0; j < 11; j++) send(WORDS[191 - 12 * j -: 12]);
      strobe();
      chk_all();
      host_model_i.idle(6);
      chk("dout", 12'h001, {11'h000, dout});
      for (j = 11; j < 16; j++) send(WORDS[191 - 12 * j -: 12]);
      send(12'h6ff);
      clear_n = 1'b0;
      cyc(6);
      clear_n = 1'b1;
      cyc(6);
      for (k = 0; k < 4; k++) inp_e[k] = 8'h00;
      for (k = 0; k < 4; k++) dac_e[k] = 8'h00;
      chk_all();
      strobe();
      chk_all();
      test_done();
   end

   // Cuts a hang short
   initial
   begin
      repeat (60000) @(posedge ref_clk);
      bad_count++;
      $display("MISMATCH watchdog expected done seen hang");
      test_done();
   end

endmodule : tb_top
